// ===== hw/tad_top.sv
// two tone detectors with power bits, status flags, irq and wishbone slave
//
// How it works
// - the call-waiting detector runs only while power control bit 7 is set.
// - the call-waiting result reads back as bit 7 of the tone status register.
// - the call-waiting flag idles high and goes low only while both tones are present.
// - the call-waiting flag falls 42 ms after a dual tone starts and rises 26 ms after it ends.
// - setting bit 5 of the tone power register powers and enables the dial tone detector.
// - the enabled dial tone detector drives status bit 5 low on 350 plus 440 Hz.
// - the dial tone is qualified by band frequency counting and then a timing check.
// - the dial tone flag goes low 30 ms after a qualifying tone appears.
// - the dial tone flag returns high 30 ms after the qualifying tone disappears.
// - writing 0 to the dial tone power bit powers it down, writing 1 powers it up.
// - the active low option bit 2 enables the dial tone function, a 1 makes it unavailable.
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module tad_top
	import tad_pkg::*;
#(
	parameter int CW_DET_CYC = CW_DETECT_CYC,
	parameter int CW_REL_CYC = CW_RELEASE_CYC,
	parameter int DT_DET_CYC = DT_DETECT_CYC,
	parameter int DT_REL_CYC = DT_RELEASE_CYC,
	parameter int DT_LO_PMIN = DT_LO_PER_MIN,
	parameter int DT_LO_PMAX = DT_LO_PER_MAX,
	parameter int DT_HI_PMIN = DT_HI_PER_MIN,
	parameter int DT_HI_PMAX = DT_HI_PER_MAX
) (
	// clock and reset
	input  wire logic        SYS_CLK,
	input  wire logic        RESETN,
	// wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [4:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	// analog front end level detectors
	input  wire logic        CW_TONE_LO,
	input  wire logic        CW_TONE_HI,
	input  wire logic        DT_BAND_LO,
	input  wire logic        DT_BAND_HI,
	// factory option word bit, active low
	input  wire logic        DIAL_TONE_OPTION_N,
	// detector power outputs to the analog side
	output logic             CW_POWER_ON,
	output logic             DT_POWER_ON,
	// interrupt
	output logic             IRQ
);
	import tad_pkg::*;

	typedef struct packed {
		logic [7:0]       power_control_reg;
		logic [7:0]       tone_power_ctrl_reg;
		logic [IRQ_W-1:0] irq_stat;
		logic [IRQ_W-1:0] irq_mask;
		logic             ack;
		logic [31:0]      dat;
		logic [1:0]       band_d;
		logic [1:0][PER_W-1:0] per;
		logic [1:0][1:0]  good;
		logic             opt_n;
	} tad_top_t;

	tad_top_t s_r;
	tad_top_t s_nxt;
	logic     rst_n;

	// reset release through two flip-flops, kept outside the state struct
	logic [1:0] rsync_r;
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rsync_r <= 2'b00;
		end else begin
			rsync_r <= {rsync_r[0], 1'b1};
		end
	end
	assign rst_n = rsync_r[1];

	tad_qual_if cw_if ();
	tad_qual_if dt_if ();

	logic       cw_en;
	logic       dt_en;
	logic [7:0] status;
	logic [IRQ_W-1:0] ev;
	logic       req;
	logic [1:0] band;
	logic [1:0][PER_W-1:0] pmin;
	logic [1:0][PER_W-1:0] pmax;

	assign cw_en = s_r.power_control_reg[CW_PWR_BIT];
	// option sampled after reset release; a 1 keeps the function off
	assign dt_en = s_r.tone_power_ctrl_reg[DT_PWR_BIT] & ~s_r.opt_n;

	assign cw_if.enable  = cw_en;
	assign cw_if.tone_ok = CW_TONE_LO & CW_TONE_HI;
	assign dt_if.enable  = dt_en;
	// both bands must hold a run of in-range periods
	assign dt_if.tone_ok = (s_r.good[0] == 2'(DT_GOOD_N)) && (s_r.good[1] == 2'(DT_GOOD_N));

	tad_qualify #(.DET_CYC(CW_DET_CYC), .REL_CYC(CW_REL_CYC)) u_cw (
		.clk   (SYS_CLK),
		.rst_n (rst_n),
		.q     (cw_if.qual)
	);

	tad_qualify #(.DET_CYC(DT_DET_CYC), .REL_CYC(DT_REL_CYC)) u_dt (
		.clk   (SYS_CLK),
		.rst_n (rst_n),
		.q     (dt_if.qual)
	);

	// qualifiers hold flags high while disabled
	always_comb begin
		status              = STATUS_RST;
		status[CW_FLAG_BIT] = cw_if.detect_n;
		status[DT_FLAG_BIT] = dt_if.detect_n;
	end

	assign ev  = {dt_if.rise, dt_if.fall, cw_if.rise, cw_if.fall};
	assign req = WB_CYC_I & WB_STB_I & ~s_r.ack;
	assign band = {DT_BAND_HI, DT_BAND_LO};
	assign pmin = {PER_W'(DT_HI_PMIN), PER_W'(DT_LO_PMIN)};
	assign pmax = {PER_W'(DT_HI_PMAX), PER_W'(DT_LO_PMAX)};

	always_comb begin
		s_nxt          = s_r;
		s_nxt.ack      = req;
		s_nxt.opt_n    = DIAL_TONE_OPTION_N;

		// band period check; a missing edge drops the band within one period
		for (int b = 0; b < 2; b++) begin
			s_nxt.band_d[b] = band[b];
			if (!dt_en) begin
				s_nxt.per[b]  = '0;
				s_nxt.good[b] = '0;
			end else if (band[b] && !s_r.band_d[b]) begin
				s_nxt.per[b] = PER_W'(1);
				if (s_r.per[b] >= pmin[b] && s_r.per[b] <= pmax[b]) begin
					if (s_r.good[b] != 2'(DT_GOOD_N)) begin
						s_nxt.good[b] = s_r.good[b] + 1'b1;
					end
				end else begin
					s_nxt.good[b] = '0;
				end
			end else if (s_r.per[b] > pmax[b]) begin
				s_nxt.good[b] = '0;
			end else begin
				s_nxt.per[b] = s_r.per[b] + 1'b1;
			end
		end

		// register writes, low byte lane only
		s_nxt.dat = '0;
		if (req && WB_WE_I && WB_SEL_I[0]) begin
			if (WB_ADR_I == 5'(ADDR_POWER_CTRL)) begin
				s_nxt.power_control_reg = WB_DAT_I[7:0];
			end else if (WB_ADR_I == 5'(ADDR_TONE_PWR)) begin
				s_nxt.tone_power_ctrl_reg = WB_DAT_I[7:0];
			end else if (WB_ADR_I == 5'(ADDR_IRQ_MASK_I)) begin
				s_nxt.irq_mask = WB_DAT_I[IRQ_W-1:0];
			end
		end
		if (req && !WB_WE_I) begin
			if (WB_ADR_I == 5'(ADDR_POWER_CTRL)) begin
				s_nxt.dat[7:0] = s_r.power_control_reg;
			end else if (WB_ADR_I == 5'(ADDR_TONE_PWR)) begin
				s_nxt.dat[7:0] = s_r.tone_power_ctrl_reg;
			end else if (WB_ADR_I == 5'(ADDR_STATUS)) begin
				s_nxt.dat[7:0] = status;
			end else if (WB_ADR_I == 5'(ADDR_IRQ_STAT)) begin
				s_nxt.dat[IRQ_W-1:0] = s_r.irq_stat;
			end else if (WB_ADR_I == 5'(ADDR_IRQ_MASK_I)) begin
				s_nxt.dat[IRQ_W-1:0] = s_r.irq_mask;
			end
		end

		// sticky events, write one to clear, set wins
		if (req && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == 5'(ADDR_IRQ_STAT)) begin
			s_nxt.irq_stat = s_r.irq_stat & ~WB_DAT_I[IRQ_W-1:0];
		end
		s_nxt.irq_stat = s_nxt.irq_stat | ev;
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			s_r         <= '0;
			s_r.opt_n   <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign WB_DAT_O    = s_r.dat;
	assign WB_ACK_O    = s_r.ack;
	assign CW_POWER_ON = cw_en;
	assign DT_POWER_ON = dt_en;
	assign IRQ         = |(s_r.irq_stat & s_r.irq_mask);
endmodule
`default_nettype wire

// ===== hw/tad_pkg.sv
// shared constants and types for the tone alert detect status block
package tad_pkg;

	localparam int CLK_HZ = 100_000_000;

	// typical timings, in ms
	localparam int CW_DETECT_MS   = 42;
	localparam int CW_RELEASE_MS  = 26;
	localparam int DT_DETECT_MS   = 30;
	localparam int DT_RELEASE_MS  = 30;

	localparam int CW_DETECT_CYC  = CW_DETECT_MS * (CLK_HZ / 1000);
	localparam int CW_RELEASE_CYC = CW_RELEASE_MS * (CLK_HZ / 1000);
	localparam int DT_DETECT_CYC  = DT_DETECT_MS * (CLK_HZ / 1000);
	localparam int DT_RELEASE_CYC = DT_RELEASE_MS * (CLK_HZ / 1000);

	// dial tone band periods in cycles, nominal frequency within the tolerance
	localparam int DT_LO_HZ      = 350;
	localparam int DT_HI_HZ      = 440;
	localparam int DT_TOL_PCT    = 2;
	localparam int DT_LO_PER_MIN = (CLK_HZ / (DT_LO_HZ * (100 + DT_TOL_PCT))) * 100;
	localparam int DT_LO_PER_MAX = (CLK_HZ / (DT_LO_HZ * (100 - DT_TOL_PCT))) * 100;
	localparam int DT_HI_PER_MIN = (CLK_HZ / (DT_HI_HZ * (100 + DT_TOL_PCT))) * 100;
	localparam int DT_HI_PER_MAX = (CLK_HZ / (DT_HI_HZ * (100 - DT_TOL_PCT))) * 100;
	// in-range periods in a row before a band counts as present
	localparam int DT_GOOD_N     = 3;
	localparam int PER_W         = 20;

	localparam int CNT_W = 32;

	// wishbone word addresses (byte offsets)
	localparam logic [3:0] ADDR_POWER_CTRL = 4'h0;
	localparam logic [3:0] ADDR_TONE_PWR   = 4'h4;
	localparam logic [3:0] ADDR_STATUS     = 4'h8;
	localparam logic [3:0] ADDR_IRQ_STAT   = 4'hc;

	localparam int ADDR_IRQ_MASK_I = 16;

	// field positions
	localparam int CW_PWR_BIT  = 7;
	localparam int CW_FLAG_BIT = 7;
	localparam int DT_PWR_BIT  = 5;
	localparam int DT_FLAG_BIT = 5;
	localparam int OPT_DT_BIT  = 2;

	// irq status bits: cw detect, cw release, dt detect, dt release
	localparam int IRQ_W = 4;

	localparam logic [7:0] STATUS_RST = 8'hff;

	typedef enum logic [1:0] {TAD_IDLE, TAD_QUAL, TAD_ON, TAD_REL} tad_qstate_t;

endpackage

// ===== hw/tad_qual_if.sv
// interface between the top and one tone qualifier
`timescale 1ns/100ps
`default_nettype none
interface tad_qual_if;
	logic enable;
	logic tone_ok;
	logic detect_n;
	logic rise;
	logic fall;
	modport ctl (output enable, output tone_ok, input detect_n, input rise, input fall);
	modport qual (input enable, input tone_ok, output detect_n, output rise, output fall);
endinterface
`default_nettype wire

// ===== hw/tad_qualify.sv
// detect and release delay qualifier with an active low flag
`timescale 1ns/100ps
`default_nettype none
module tad_qualify
	import tad_pkg::*;
#(
	parameter int DET_CYC = 1000,
	parameter int REL_CYC = 1000
) (
	// clock and reset
	input wire logic   clk,
	input wire logic   rst_n,
	// link to the top
	tad_qual_if.qual   q
);
	typedef struct packed {
		tad_qstate_t      st;
		logic [CNT_W-1:0] cnt;
		logic             det_n;
		logic             rise;
		logic             fall;
	} tad_qual_t;

	tad_qual_t s_r;
	tad_qual_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.rise = 1'b0;
		s_nxt.fall = 1'b0;
		if (!q.enable) begin
			s_nxt.st    = TAD_IDLE;
			s_nxt.cnt   = '0;
			s_nxt.det_n = 1'b1;
		end else begin
			unique case (s_r.st)
				TAD_IDLE: begin
					s_nxt.cnt = '0;
					if (q.tone_ok) begin
						s_nxt.st = TAD_QUAL;
					end
				end
				TAD_QUAL: begin
					if (!q.tone_ok) begin
						s_nxt.st = TAD_IDLE;
					end else if (s_r.cnt >= CNT_W'(DET_CYC - 2)) begin
						s_nxt.st    = TAD_ON;
						s_nxt.det_n = 1'b0;
						s_nxt.fall  = 1'b1;
						s_nxt.cnt   = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + 1'b1;
					end
				end
				TAD_ON: begin
					s_nxt.cnt = '0;
					if (!q.tone_ok) begin
						s_nxt.st = TAD_REL;
					end
				end
				TAD_REL: begin
					if (q.tone_ok) begin
						s_nxt.st  = TAD_ON;
						s_nxt.cnt = '0;
					end else if (s_r.cnt >= CNT_W'(REL_CYC - 2)) begin
						s_nxt.st    = TAD_IDLE;
						s_nxt.det_n = 1'b1;
						s_nxt.rise  = 1'b1;
						s_nxt.cnt   = '0;
					end else begin
						s_nxt.cnt = s_r.cnt + 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{st: TAD_IDLE, cnt: '0, det_n: 1'b1, rise: 1'b0, fall: 1'b0};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign q.detect_n = s_r.det_n;
	assign q.rise     = s_r.rise;
	assign q.fall     = s_r.fall;
endmodule
`default_nettype wire

// ===== sim/tad_top_sva.sv
// concurrent checks on the tone alert detect status top ports
`timescale 1ns/100ps
`default_nettype none
module tad_top_sva (
	// clock, reset and bus
	input wire logic	SYS_CLK,
	input wire logic	RESETN,
	input wire logic	WB_CYC_I,
	input wire logic	WB_STB_I,
	input wire logic	WB_WE_I,
	input wire logic [4:0]	WB_ADR_I,
	input wire logic [31:0]	WB_DAT_O,
	input wire logic	WB_ACK_O,
	// option, power and irq
	input wire logic	DIAL_TONE_OPTION_N,
	input wire logic	CW_POWER_ON,
	input wire logic	DT_POWER_ON,
	input wire logic	IRQ
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	sequence wb_req;
		WB_CYC_I && WB_STB_I && !WB_ACK_O;
	endsequence
	sequence st_read;
		WB_ACK_O && !WB_WE_I && WB_ADR_I == 5'h08;
	endsequence
	ack_latency_a: assert property (wb_req |=> WB_ACK_O) else $error("ack late");
	ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack long");
	dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data idle");
	rd_status_a: assert property (st_read |-> WB_DAT_O[31:8] == 24'h0 && WB_DAT_O[6]
		&& WB_DAT_O[4:0] == 5'h1f) else $error("status spare bits");
	off_flag_a: assert property (st_read |-> (CW_POWER_ON || WB_DAT_O[7])
		&& (DT_POWER_ON || WB_DAT_O[5])) else $error("flag while off");
	cw_power_a: assert property ($changed(CW_POWER_ON) |-> $rose(WB_ACK_O) && WB_WE_I
		&& WB_ADR_I == 5'h00) else $error("cw power change");
	dt_option_a: assert property (DIAL_TONE_OPTION_N [*2] |-> !DT_POWER_ON)
		else $error("dt power with option off");
	irq_clear_a: assert property ($fell(IRQ) |-> WB_ACK_O || $past(WB_ACK_O))
		else $error("irq fell without write");
endmodule
bind tad_top tad_top_sva u_sva (.SYS_CLK, .RESETN, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
	.WB_DAT_O, .WB_ACK_O, .DIAL_TONE_OPTION_N, .CW_POWER_ON, .DT_POWER_ON, .IRQ);
`default_nettype wire

// ===== sim/tad_afe_model.sv
// line side stand-in: tone level detectors and band squarers
`timescale 1ns/100ps
`default_nettype none
module tad_afe_model (
	// clock and tone commands
	input wire logic	clk,
	input wire logic	lo_on,
	input wire logic	hi_on,
	input wire logic	dt_on,
	// detector outputs
	output var logic	cw_lo = 1'b0,
	output var logic	cw_hi = 1'b0,
	output var logic	dt_lo = 1'b0,
	output var logic	dt_hi = 1'b0
);
	logic [5:0]	lo_c = 6'h0;
	logic [5:0]	hi_c = 6'h0;
	// squarers of 56 and 46 cycle period, low when silent
	always_ff @(posedge clk) begin
		lo_c <= (lo_c == 6'h37) ? 6'h0 : lo_c + 6'h1;
		hi_c <= (hi_c == 6'h2d) ? 6'h0 : hi_c + 6'h1;
		cw_lo <= lo_on;
		cw_hi <= hi_on;
		dt_lo <= dt_on && lo_c < 6'h1c;
		dt_hi <= dt_on && hi_c < 6'h17;
	end
endmodule
`default_nettype wire

// ===== sim/tad_top_tb.sv
// self-checking bench for the tone alert detect status top
`timescale 1ns/100ps
`default_nettype none
module tad_top_tb;
	localparam int CWD = 20;
	localparam int CWR = 12;
	logic		clk = 1'b0;
	logic		rst_n = 1'b0;
	logic		cyc = 1'b0;
	logic		we = 1'b0;
	logic [4:0]	adr = 5'h0;
	logic [31:0]	dat = 32'h0;
	logic		opt_n = 1'b1;
	logic		lo_on = 1'b0;
	logic		hi_on = 1'b0;
	logic		dt_on = 1'b0;
	logic [31:0]	dat_o;
	logic [31:0]	rd;
	logic		ack, irq, cw_pwr, dt_pwr, cw_lo, cw_hi, dt_lo, dt_hi;
	int		err_count = 0;
	int		n_checks = 0;
	int		n;
	always #5 clk = ~clk;
	tad_top #(.CW_DET_CYC(CWD), .CW_REL_CYC(CWR), .DT_DET_CYC(16), .DT_REL_CYC(16),
		.DT_LO_PMIN(54), .DT_LO_PMAX(58), .DT_HI_PMIN(44), .DT_HI_PMAX(48))
		dut (.SYS_CLK(clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_ACK_O(ack), .CW_TONE_LO(cw_lo), .CW_TONE_HI(cw_hi), .DT_BAND_LO(dt_lo),
		.DT_BAND_HI(dt_hi), .DIAL_TONE_OPTION_N(opt_n), .CW_POWER_ON(cw_pwr),
		.DT_POWER_ON(dt_pwr), .IRQ(irq));
	tad_afe_model afe (.clk, .lo_on, .hi_on, .dt_on, .cw_lo, .cw_hi, .dt_lo, .dt_hi);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int t = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1);
		rd = dat_o;
		cyc <= 1'b0;
		chk("ack delay", 32'd2, 32'(t));
	endtask
	task automatic wait_irq(input int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic t_regs;
		for (int a = 0; a < 24; a += 4) begin
			wb(1'b0, 5'(a), 32'h0);
			chk("reset value", (a == 8) ? 32'hff : 32'h0, rd);
		end
		wb(1'b1, 5'h14, 32'hff);
		wb(1'b0, 5'h14, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("registers done");
	endtask
	task automatic t_cw;
		wb(1'b1, 5'h10, 32'h3);
		lo_on <= 1'b1;
		hi_on <= 1'b1;
		repeat (40) @(posedge clk);
		wb(1'b0, 5'h08, 32'h0);
		chk("cw unpowered", 32'hff, rd);
		hi_on <= 1'b0;
		wb(1'b1, 5'h00, 32'h80);
		chk("cw power", 1'b1, cw_pwr);
		repeat (40) @(posedge clk);
		chk("single tone", 1'b0, irq);
		hi_on <= 1'b1;
		wait_irq(40);
		chk("cw detect", 1'b1, n >= CWD && n <= CWD + 6);
		wb(1'b0, 5'h08, 32'h0);
		chk("cw flag", 32'h7f, rd);
		wb(1'b1, 5'h0c, 32'h1);
		@(posedge clk);
		chk("irq clear", 1'b0, irq);
		repeat (8) @(posedge clk); // tone near its nominal scaled length
		lo_on <= 1'b0;
		wait_irq(40);
		chk("cw release", 1'b1, n >= CWR && n <= CWR + 6);
		wb(1'b1, 5'h0c, 32'h2);
		wb(1'b1, 5'h00, 32'h0);
		$display("call waiting done");
	endtask
	task automatic t_dt;
		wb(1'b1, 5'h04, 32'h20);
		chk("option off", 1'b0, dt_pwr);
		opt_n <= 1'b0;
		wb(1'b1, 5'h10, 32'h4);
		chk("dt power", 1'b1, dt_pwr);
		dt_on <= 1'b1;
		wait_irq(5 * 56 + 16);
		chk("dt detect", 1'b1, irq === 1'b1 && n > 3 * 56);
		repeat (300) @(posedge clk);
		wb(1'b0, 5'h0c, 32'h0);
		chk("dt steady events", 32'h4, rd);
		wb(1'b0, 5'h08, 32'h0);
		chk("dt flag", 32'hdf, rd);
		wb(1'b1, 5'h0c, 32'hf);
		wb(1'b1, 5'h10, 32'h8);
		dt_on <= 1'b0;
		wait_irq(2 * 56 + 16);
		chk("dt release", 1'b1, irq === 1'b1 && n > 16);
		wb(1'b0, 5'h08, 32'h0);
		chk("dt release flag", 32'hff, rd);
		wb(1'b1, 5'h0c, 32'hf);
		wb(1'b1, 5'h10, 32'h4);
		dt_on <= 1'b1;
		wait_irq(5 * 56 + 16);
		chk("dt redetect", 1'b1, irq);
		wb(1'b1, 5'h04, 32'h0);
		chk("dt off", 1'b0, dt_pwr);
		wb(1'b0, 5'h08, 32'h0);
		chk("dt off flag", 32'hff, rd);
		wb(1'b1, 5'h04, 32'h20);
		opt_n <= 1'b1;
		wb(1'b0, 5'h08, 32'h0);
		chk("option withdrawn", 1'b0, dt_pwr);
		$display("dial tone done");
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_cw();
		t_dt();
		results();
	end
	initial begin
		#200000;
		err_count++;
		results();
	end
endmodule
`default_nettype wire
